// file: hw/ddrb_burst_top.sv
// DDR2 column burst engine with posted commands and APB status
// Summary of operation
// - Column commands accepted any time after activate, executed AL clocks later.
// - Read latency equals additive latency plus CAS latency.
// - Write latency is read latency minus one clock.
// - Only four-beat and eight-beat bursts exist.
// - Mode register address bit 3 selects sequential or interleaved order.
// - Column order follows start bits; sequential wraps nibble, interleaved XORs.
// - READ decoded with CS, CAS low and RAS, WE high.
// - First read beat appears exactly read latency clocks after READ.
// - Strobe driven low one clock before read data, beats on strobe edges.
// - CL from mode register, AL from extended mode register one.
// - Extended mode bit enables the complementary strobe only in differential mode.
// - READs every two or four clocks give gapless read data.
// - Eight-beat read cut by any READ one to three clocks later.
// - Timing follows programmed burst length even after an interrupt.
// - WRITE decoded with CS, CAS, WE low and RAS high.
// - Data beyond the programmed write beats is ignored.
// - Address bit 10 high with READ or WRITE closes bank after burst.
module ddrb_burst_top
  import ddrb_pkg::*;
#(
  parameter int MAXLAT = 16,
  parameter int COLW = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command pins
  input wire logic ck,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [BA_W-1:0] ba,
  input wire logic [APIN_W-1:0] addr,
  // Data and strobes
  input wire logic [DQ_W-1:0] dqIn,
  output logic [DQ_W-1:0] dqOut,
  output logic dqOe,
  input wire logic dqsIn,
  output logic dqsOut,
  output logic dqsOe,
  output logic dqsNOut,
  output logic dqsNOe
);
  localparam int PW = 1 + 4 + BA_W + APIN_W + 1 + DQ_W;
  localparam int MEMD = 2 ** (COLW + BA_W);

  if (MAXLAT < LAT_TAP_MAX || MAXLAT > 16 || COLW < 3 || COLW > 10) begin : g_chk
    $error("ddrb_burst_top parameters out of range");
  end

  logic [PW-1:0] pinS;
  logic ckS, ckP, dqsS, dqsP;
  logic [3:0] cmdS;
  logic [BA_W-1:0] baS;
  logic [APIN_W-1:0] addrS;
  logic [DQ_W-1:0] dqS;
  logic ckRise, ckFall, dqsRise, dqsFall;
  logic ctrlEn;
  logic [2:0] cl, al;
  logic bl8, ilv, diffDqs;
  logic [3:0] rl, wl, wlm1, blBeats;
  logic cmdOk, isRd, isWr, isMrs, isAct, isPre;
  logic [MAXLAT-1:0] pV, pW, pAp;
  logic [BA_W-1:0] pBa [MAXLAT];
  logic [COLW-1:0] pCol [MAXLAT];
  logic rdGo, rdPre, wrGo;
  logic [DQ_W-1:0] mem [MEMD];
  ddrb_bus_t busState;
  logic [3:0] rdLeft, wrLeft;
  logic [2:0] rdBeat, wrBeat, rdStart, wrStart, rdCol, wrCol;
  logic [BA_W+COLW-4:0] rdHi, wrHi;
  logic rdAp, wrAp, wrFirst, capture;
  logic [BA_W-1:0] rdBank, wrBank;
  logic [3:0] bankOpen;
  logic [31:0] statusWord;

  ddrb_sync #(.W(PW)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({ck, csN, rasN, casN, weN, ba, addr, dqsIn, dqIn}),
    .dout(pinS)
  );

  assign {ckS, cmdS, baS, addrS, dqsS, dqS} = pinS;

  // Previous samples for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ckP <= 1'b0;
      dqsP <= 1'b0;
    end else begin
      ckP <= ckS;
      dqsP <= dqsS;
    end
  end

  assign ckRise = ckS && !ckP;
  assign ckFall = !ckS && ckP;
  assign dqsRise = dqsS && !dqsP;
  assign dqsFall = !dqsS && dqsP;

  assign cmdOk = ckRise && ctrlEn && !cmdS[3];
  assign isRd = cmdOk && cmdS[2:0] == CMD_RD;
  assign isWr = cmdOk && cmdS[2:0] == CMD_WR;
  assign isMrs = cmdOk && cmdS[2:0] == CMD_MRS;
  assign isAct = cmdOk && cmdS[2:0] == CMD_ACT;
  assign isPre = cmdOk && cmdS[2:0] == CMD_PRE;

  // Mode registers loaded from the pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cl <= CL_RST;
      al <= AL_RST;
      bl8 <= BL8_RST;
      ilv <= ILV_RST;
      diffDqs <= DIFF_RST;
    end else if (isMrs && baS == BA_MRS) begin
      if (addrS[MR_BL_LSB +: 3] == BL_CODE4 || addrS[MR_BL_LSB +: 3] == BL_CODE8) begin
        bl8 <= addrS[MR_BL_LSB +: 3] == BL_CODE8;
      end
      ilv <= addrS[MR_BT_BIT];
      if (addrS[MR_CL_LSB +: 3] >= CL_MIN) begin
        cl <= addrS[MR_CL_LSB +: 3];
      end
    end else if (isMrs && baS == BA_EMRS1) begin
      if (addrS[EMR_AL_LSB +: 3] <= AL_MAX) begin
        al <= addrS[EMR_AL_LSB +: 3];
      end
      diffDqs <= !addrS[EMR_DQSN_BIT];
    end
  end

  assign rl = {1'b0, al} + {1'b0, cl};
  assign wl = rl - 4'h1;
  assign wlm1 = wl - 4'h1;
  assign blBeats = bl8 ? BEATS8 : BEATS4;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pV <= '0;
      pW <= '0;
      pAp <= '0;
    end else if (ckRise) begin
      pV <= {pV[MAXLAT-2:0], isRd || isWr};
      pW <= {pW[MAXLAT-2:0], isWr};
      pAp <= {pAp[MAXLAT-2:0], addrS[AP_BIT]};
    end
  end

  always_ff @(posedge mclk) begin
    if (ckRise) begin
      pBa[0] <= baS;
      pCol[0] <= addrS[COLW-1:0];
      for (int i = 1; i < MAXLAT; i++) begin
        pBa[i] <= pBa[i-1];
        pCol[i] <= pCol[i-1];
      end
    end
  end

  // Taps seen before the shift, so index wl means rl edges
  assign rdGo = ckRise && pV[wl] && !pW[wl];
  assign rdPre = ckRise && pV[wlm1] && !pW[wlm1];
  assign wrGo = ckRise && pV[wlm1] && pW[wlm1];

  ddrb_order u_rdOrder (
    .start(rdStart),
    .beat(rdBeat),
    .bl8(bl8),
    .ilv(ilv),
    .col(rdCol)
  );

  ddrb_order u_wrOrder (
    .start(wrStart),
    .beat(wrBeat),
    .bl8(bl8),
    .ilv(ilv),
    .col(wrCol)
  );

  // Read burst output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdLeft <= 4'h0;
      rdBeat <= 3'h0;
      rdStart <= 3'h0;
      rdHi <= '0;
      rdAp <= 1'b0;
      rdBank <= '0;
      dqOut <= '0;
      dqOe <= 1'b0;
      dqsOut <= 1'b0;
      dqsOe <= 1'b0;
      dqsNOut <= 1'b0;
      dqsNOe <= 1'b0;
    end else if (rdGo) begin
      // a new read restarts a four- or eight-beat burst
      rdLeft <= blBeats - 4'h1;
      rdBeat <= 3'h1;
      rdStart <= pCol[wl][2:0];
      rdHi <= {pBa[wl], pCol[wl][COLW-1:3]};
      rdAp <= pAp[wl];
      rdBank <= pBa[wl];
      dqOut <= mem[{pBa[wl], pCol[wl]}];
      dqOe <= 1'b1;
      dqsOut <= 1'b1;
      dqsOe <= 1'b1;
      dqsNOut <= 1'b0;
      dqsNOe <= diffDqs;
    end else if ((ckRise || ckFall) && rdLeft != 4'h0) begin
      dqOut <= mem[{rdHi, rdCol}];
      dqsOut <= ckRise;
      dqsNOut <= !ckRise;
      rdLeft <= rdLeft - 4'h1;
      rdBeat <= rdBeat + 3'h1;
    end else if (rdPre && rdLeft == 4'h0) begin
      dqsOe <= 1'b1;
      dqsOut <= 1'b0;
      dqsNOe <= diffDqs;
      dqsNOut <= 1'b1;
      dqOe <= 1'b0;
    end else if (ckRise) begin
      // Half-clock postamble ends here
      dqOe <= 1'b0;
      dqsOe <= 1'b0;
      dqsOut <= 1'b0;
      dqsNOe <= 1'b0;
      dqsNOut <= 1'b0;
    end
  end

  // first beat waits for a strobe rise
  // nothing taken once the count is spent
  assign capture = wrLeft != 4'h0 && (dqsRise || (dqsFall && !wrFirst));

  // Write burst capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrLeft <= 4'h0;
      wrBeat <= 3'h0;
      wrStart <= 3'h0;
      wrHi <= '0;
      wrAp <= 1'b0;
      wrBank <= '0;
      wrFirst <= 1'b0;
    end else if (wrGo) begin
      wrLeft <= blBeats;
      wrBeat <= 3'h0;
      wrStart <= pCol[wlm1][2:0];
      wrHi <= {pBa[wlm1], pCol[wlm1][COLW-1:3]};
      wrAp <= pAp[wlm1];
      wrBank <= pBa[wlm1];
      wrFirst <= 1'b1;
    end else if (capture) begin
      wrLeft <= wrLeft - 4'h1;
      wrBeat <= wrBeat + 3'h1;
      wrFirst <= 1'b0;
    end
  end

  // Array has no reset, its content is undefined after power up
  always_ff @(posedge mclk) begin
    if (capture) begin
      mem[{wrHi, wrCol}] <= dqS;
    end
  end

  // Data bus direction, for status only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= DB_IDLE;
    end else if (rdGo || rdLeft != 4'h0) begin
      busState <= DB_READ;
    end else if (wrGo || wrLeft != 4'h0) begin
      busState <= DB_WRITE;
    end else begin
      busState <= DB_IDLE;
    end
  end

  // Open banks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bankOpen <= 4'h0;
    end else begin
      if (isAct) begin
        bankOpen[baS] <= 1'b1;
      end
      if (isPre && addrS[AP_BIT]) begin
        bankOpen <= 4'h0;
      end else if (isPre) begin
        bankOpen[baS] <= 1'b0;
      end
      // auto precharge closes after last beat
      if (rdAp && rdLeft == 4'h1 && (ckRise || ckFall) && !rdGo) begin
        bankOpen[rdBank] <= 1'b0;
      end
      if (wrAp && wrLeft == 4'h1 && capture && !wrGo) begin
        bankOpen[wrBank] <= 1'b0;
      end
    end
  end

  always_comb begin
    statusWord = 32'h0;
    statusWord[ST_CL +: 3] = cl;
    statusWord[ST_AL +: 3] = al;
    statusWord[ST_BL8] = bl8;
    statusWord[ST_ILV] = ilv;
    statusWord[ST_DIFF] = diffDqs;
    statusWord[ST_BANK +: 4] = bankOpen;
    statusWord[ST_RD] = busState == DB_READ;
    statusWord[ST_WR] = busState == DB_WRITE;
  end

  // APB answer prepared in setup, shown in the single access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        if (paddr == OFS_CTRL) begin
          prdata <= {31'h0, ctrlEn};
          pslverr <= 1'b0;
        end else if (paddr == OFS_STAT) begin
          prdata <= statusWord;
          pslverr <= 1'b0;
        end else begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Command enable written by software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlEn <= CTRL_EN_RST;
    end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
      ctrlEn <= pwdata[CTRL_EN_BIT];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_rdBeat;
    (ckRise || ckFall) && rdLeft != 4'h0 && !rdGo;
  endsequence

  property p_rdDecode;
    isRd |=> pV[0] && !pW[0] && pCol[0] == $past(addrS[COLW-1:0]);
  endproperty
  a_rdDecode: assert property (p_rdDecode) else $error("read not queued");

  property p_wrDecode;
    isWr |=> pV[0] && pW[0] && pBa[0] == $past(baS);
  endproperty
  a_wrDecode: assert property (p_wrDecode) else $error("write not queued");

  property p_firstBeat;
    rdGo |=> dqOe && dqsOe && dqsOut && rdLeft == blBeats - 4'h1;
  endproperty
  a_firstBeat: assert property (p_firstBeat) else $error("first read beat wrong");

  property p_preamble;
    rdPre && rdLeft == 4'h0 && !rdGo |=> dqsOe && !dqsOut && !dqOe;
  endproperty
  a_preamble: assert property (p_preamble) else $error("no read preamble");

  property p_twoBeats;
    s_rdBeat |=> rdLeft == $past(rdLeft) - 4'h1 && dqsOut == $past(ckRise);
  endproperty
  a_twoBeats: assert property (p_twoBeats) else $error("beat not on strobe edge");

  property p_ignore;
    wrLeft == 4'h0 && !wrGo |=> wrLeft == 4'h0 && $stable(wrBeat);
  endproperty
  a_ignore: assert property (p_ignore) else $error("extra write beat taken");

  property p_dqsn;
    dqsNOe |-> diffDqs && dqsNOut == !dqsOut;
  endproperty
  a_dqsn: assert property (p_dqsn) else $error("complement strobe misused");

  property p_order;
    capture && wrBeat == 3'h4 |-> wrCol[2] != wrStart[2] && bl8;
  endproperty
  a_order: assert property (p_order) else $error("nibble order wrong");
endmodule : ddrb_burst_top

// file: hw/ddrb_order.sv
// Column order within a burst for one beat
module ddrb_order
  import ddrb_pkg::*;
(
  // Burst setup
  input wire logic [2:0] start,
  input wire logic [2:0] beat,
  input wire logic bl8,
  input wire logic ilv,
  // Ordered column bits
  output logic [2:0] col
);
  always_comb begin
    // Nibble other than the start one is visited second in eight-beat bursts
    col[2] = start[2] ^ (bl8 & beat[2]);
    if (ilv) begin
      col[1:0] = start[1:0] ^ beat[1:0];
    end else begin
      col[1:0] = start[1:0] + beat[1:0];
    end
  end
endmodule : ddrb_order

// file: hw/ddrb_pkg.sv
// Shared constants for the DDR2 column burst engine
package ddrb_pkg;
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'h1;
  // Status field positions
  localparam int ST_CL = 0;
  localparam int ST_AL = 3;
  localparam int ST_BL8 = 6;
  localparam int ST_ILV = 7;
  localparam int ST_DIFF = 8;
  localparam int ST_BANK = 9;
  localparam int ST_RD = 13;
  localparam int ST_WR = 14;
  // Pin widths
  localparam int DQ_W = 16;
  localparam int APIN_W = 13;
  localparam int BA_W = 2;
  // Command codes on {ras, cas, we} with chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  // Mode register selects and address fields
  localparam logic [1:0] BA_MRS = 2'h0;
  localparam logic [1:0] BA_EMRS1 = 2'h1;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_DQSN_BIT = 10;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [3:0] BEATS4 = 4'h4;
  localparam logic [3:0] BEATS8 = 4'h8;
  // Mode reset values and limits
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] CL_MIN = 3'h2;
  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] AL_MAX = 3'h5;
  localparam logic BL8_RST = 1'h0;
  localparam logic ILV_RST = 1'h0;
  localparam logic DIFF_RST = 1'h1;
  // Pipeline depth needed: deepest tap (AL_MAX + largest CL - 1) plus one
  localparam int LAT_TAP_MAX = 12;
  typedef enum logic [1:0] {DB_IDLE, DB_READ, DB_WRITE} ddrb_bus_t;
endpackage : ddrb_pkg

// file: hw/ddrb_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
module ddrb_sync
  import ddrb_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_chk
    $error("ddrb_sync width must be positive");
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : ddrb_sync

// file: sim/ddrb_ctrl_model.sv
// Memory controller model: link clock, commands and write bursts
module ddrb_ctrl_model
  import ddrb_pkg::*;
(
  // System clock
  input wire logic mclk,
  // Command pins
  output logic ck,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [BA_W-1:0] ba,
  output logic [APIN_W-1:0] addr,
  // Write data and strobe
  output logic [DQ_W-1:0] dqIn,
  output logic dqsIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph = 3'h0;
  logic dqsDrv = 1'b0;
  int ckRise = 0;
  int lastRise = 0;
  initial begin
    {csN, rasN, casN, weN} = 4'hf;
    ba = '0;
    addr = '0;
    dqIn = '0;
    dqsIn = 1'b0;
  end
  // Free running, eight system clocks a period
  assign ck = ~ph[2];
  always @(posedge mclk) begin
    ph <= ph + 3'h1;
    if (ph == 3'h7) ckRise <= ckRise + 1;
    // Released strobe keeps moving, never a clean level
    if (!dqsDrv) dqsIn <= ~dqsIn;
  end
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge mclk iff ph == 3'h3);
    lastRise = ckRise + 1;
    csN <= 1'b0;
    {rasN, casN, weN} <= c;
    ba <= b;
    addr <= a;
    @(posedge mclk iff ph == 3'h3);
    csN <= 1'b1;
    {rasN, casN, weN} <= ~c;
    ba <= ~b;
    addr <= ~a;
  endtask : cmd
  // preamble, then a beat on each strobe edge
  task automatic wr(input logic [1:0] b, input logic [12:0] a, input int wl,
                    input logic [15:0] d [$]);
    cmd(CMD_WR, b, a);
    repeat (wl - 2) @(posedge mclk iff ph == 3'h3);
    dqsDrv = 1'b1;
    @(posedge mclk);
    dqsIn <= 1'b0;
    @(posedge mclk iff ph == 3'h7);
    foreach (d[k]) begin
      @(posedge mclk iff ph == ((k % 2) ? 3'h3 : 3'h7));
      dqIn <= d[k];
      // Strobe centred in the data eye
      repeat (2) @(posedge mclk);
      dqsIn <= (k % 2 == 0);
    end
    @(posedge mclk iff ph == 3'h3);
    dqIn <= ~dqIn;
    @(posedge mclk iff ph == 3'h7);
    dqsDrv = 1'b0;
  endtask : wr
endmodule : ddrb_ctrl_model

// file: sim/tb_ddr2_burst_read_write.sv
// Self-checking bench for the DDR2 column burst engine
module tb_ddr2_burst_read_write
  import ddrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rq;
  logic pready, pslverr, re, ck, csN, rasN, casN, weN;
  logic [BA_W-1:0] ba;
  logic [APIN_W-1:0] addr;
  logic [DQ_W-1:0] dqIn, dqOut;
  logic dqOe, dqsIn, dqsOut, dqsOe, dqsNOut, dqsNOe;
  int mismatches = 0;
  int checks_done = 0;
  int tick = 0;
  int preT = 0;
  int curAl = 0;
  int curCl = 3;
  logic curB8 = 1'b0;
  logic curIl = 1'b0;
  logic curSe = 1'b0;
  logic prevDqs = 1'b0;
  logic prevOe = 1'b0;
  logic sawN = 1'b0;
  logic nBad = 1'b0;
  logic [15:0] mem [8];
  logic [15:0] cap [$];
  int capRise [$];
  int capT [$];

  always #2 mclk = ~mclk;

  ddrb_burst_top #(.MAXLAT(16), .COLW(6)) dut (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ck(ck), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .ba(ba), .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsIn),
    .dqsOut(dqsOut), .dqsOe(dqsOe), .dqsNOut(dqsNOut), .dqsNOe(dqsNOe)
  );
  ddrb_ctrl_model ctl (
    .mclk(mclk), .ck(ck), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .ba(ba), .addr(addr), .dqIn(dqIn), .dqsIn(dqsIn)
  );

  // A beat is taken on each strobe change while data is driven
  always @(posedge mclk) begin
    tick++;
    prevDqs <= dqsOut;
    prevOe <= dqsOe;
    if (dqsOe === 1'b1 && prevOe === 1'b0) preT = tick;
    if (dqsNOe === 1'b1) sawN = 1'b1;
    if (dqsNOe === 1'b1 && dqsNOut !== !dqsOut) nBad = 1'b1;
    if (dqOe === 1'b1 && dqsOut !== prevDqs) begin
      cap.push_back(dqOut);
      capRise.push_back(ctl.ckRise);
      capT.push_back(tick);
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rreg(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rq, x);
  endtask : rreg

  function automatic logic [31:0] stat(input logic [3:0] bk);
    return (32'(curCl) << ST_CL) | (32'(curAl) << ST_AL) | (32'(curB8) << ST_BL8)
      | (32'(curIl) << ST_ILV) | (32'(!curSe) << ST_DIFF) | (32'(bk) << ST_BANK);
  endfunction : stat

  function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] k);
    logic [2:0] c;
    c = curIl ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
    if (!curB8) c[2] = s[2];
    return c;
  endfunction : ord

  task automatic mode(input int cl, input int al, input logic b8, input logic il,
                      input logic se);
    ctl.cmd(CMD_MRS, BA_MRS, 13'({3'(cl), il, (b8 ? BL_CODE8 : BL_CODE4)}));
    ctl.cmd(CMD_MRS, BA_EMRS1, 13'({se, 4'h0, 3'(al), 3'h0}));
    curCl = cl;
    curAl = al;
    curB8 = b8;
    curIl = il;
    curSe = se;
    repeat (24) @(posedge mclk);
  endtask : mode

  task automatic rd(input logic [2:0] st, input logic ap, input logic fresh);
    if (fresh) begin
      cap.delete();
      capRise.delete();
      capT.delete();
      sawN = 1'b0;
      nBad = 1'b0;
    end
    ctl.cmd(CMD_RD, 2'h0, {2'h0, ap, 7'h0, st});
  endtask : rd

  task automatic waitb(input int n);
    int k = 0;
    while (cap.size() < n && k < 600) begin
      @(posedge mclk);
      k++;
    end
    repeat (48) @(posedge mclk);
  endtask : waitb

  task automatic chkseq(input logic [2:0] c [$]);
    chk("beats", 32'(cap.size()), 32'(c.size()));
    foreach (c[k]) if (k < cap.size()) chk("beat", 32'(cap[k]), 32'(mem[c[k]]));
  endtask : chkseq

  task automatic modseq(input int n);
    logic [2:0] c [$];
    for (int k = 0; k < n; k++) c.push_back(3'(k));
    chkseq(c);
  endtask : modseq

  task automatic rdtest(input logic [2:0] st);
    logic [2:0] c [$];
    rd(st, 1'b0, 1'b1);
    waitb(curB8 ? 8 : 4);
    for (int k = 0; k < (curB8 ? 8 : 4); k++) c.push_back(ord(st, 3'(k)));
    chkseq(c);
    if (cap.size() > 1) begin
      chk("latency", 32'(capRise[0] - ctl.lastRise), 32'(curAl + curCl));
      chk("preamble", 32'(capT[0] - preT), 32'h8);
      chk("pitch", 32'(capT[1] - capT[0]), 32'h4);
    end
    chk("dqsNOe", 32'(sawN), 32'(!curSe));
    chk("dqsNOut", 32'(nBad), 32'h0);
  endtask : rdtest

  task automatic wrt(input int n, input logic [15:0] base);
    logic [15:0] d [$];
    for (int k = 0; k < n; k++) d.push_back(base + 16'(k) * 16'h0111);
    ctl.wr(2'h0, 13'h0, curAl + curCl - 1, d);
    for (int k = 0; k < (curB8 ? 8 : 4); k++) mem[k] = d[k];
    repeat (80) @(posedge mclk);
  endtask : wrt

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rreg(OFS_STAT, stat(4'h0), "status");
    rreg(OFS_CTRL, 32'h1, "ctrl");
    apb(1'b0, 8'h08, 32'h0);
    chk("pslverr", 32'(re), 32'h1);
    chk("prdata", rq, 32'h0);
    // nonzero AL before an early column command
    mode(3, 2, 1'b1, 1'b0, 1'b0);
    ctl.cmd(CMD_ACT, 2'h0, 13'h0001);
    wrt(8, 16'h3c00);
    rreg(OFS_STAT, stat(4'h1), "status");
    for (int i = 0; i < 4; i++) begin
      mode(3, 2, i[1], i[0], 1'b0);
      for (int s = 0; s < 8; s++) rdtest(3'(s));
    end
    ctl.cmd(CMD_MRS, BA_MRS, 13'({3'h3, 1'b1, 3'h1}));
    repeat (24) @(posedge mclk);
    rreg(OFS_STAT, stat(4'h1), "status");
    // four-beat write trailed by stray beats
    mode(3, 2, 1'b0, 1'b0, 1'b0);
    wrt(6, 16'hc300);
    mode(3, 2, 1'b1, 1'b0, 1'b0);
    rdtest(3'h0);
    mode(3, 2, 1'b0, 1'b0, 1'b0);
    rd(3'h0, 1'b0, 1'b1);
    rd(3'h4, 1'b0, 1'b0);
    waitb(8);
    modseq(8);
    if (capT.size() > 4) chk("gap", 32'(capT[4] - capT[3]), 32'h4);
    mode(3, 2, 1'b1, 1'b0, 1'b0);
    rd(3'h0, 1'b0, 1'b1);
    rd(3'h4, 1'b0, 1'b0);
    waitb(12);
    modseq(12);
    // auto precharge on an uninterrupted read
    rd(3'h0, 1'b1, 1'b1);
    waitb(8);
    rreg(OFS_STAT, stat(4'h0), "status");
    apb(1'b1, OFS_CTRL, 32'h0);
    rd(3'h0, 1'b0, 1'b1);
    waitb(1);
    chk("beats", 32'(cap.size()), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    mode(4, 0, 1'b1, 1'b0, 1'b1);
    rreg(OFS_STAT, stat(4'h0), "status");
    ctl.cmd(CMD_ACT, 2'h0, 13'h0002);
    // no AL, so the activate gap is waited out
    repeat (64) @(posedge mclk);
    rdtest(3'h5);
    finish_test();
  end

  initial begin
    #200us;
    mismatches++;
    finish_test();
  end
endmodule : tb_ddr2_burst_read_write
